// ---- shared/adc_out_pkg.sv ----
// Package with register map, field positions, reset values and timing constants of the output control block.
package adc_out_pkg;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] addr_output_mode = 8'h14;
  localparam logic [7:0] addr_power_mode = 8'h08;
  localparam logic [7:0] addr_clock_control = 8'h09;
  localparam logic [7:0] addr_requant_control = 8'h3c;
  localparam logic [7:0] addr_band_tuning = 8'h3e;
  localparam logic [7:0] addr_channel_enable = 8'h40;
  localparam logic [7:0] addr_status = 8'h44;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int fmt_lsb = 0;
  localparam int out_disable_bit = 4;
  localparam int pd_mode_lsb = 0;
  localparam int dcs_enable_bit = 0;
  localparam int requant_en_a_bit = 0;
  localparam int requant_en_b_bit = 1;
  localparam int requant_mode_lsb = 2;
  localparam int tuning_lsb = 0;

  // ==========================================================================
  // Encodings and reset values
  // ==========================================================================
  typedef enum logic [1:0] {
    fmt_offset_binary = 2'b00,
    fmt_twos_complement = 2'b01,
    fmt_gray = 2'b10
  } data_format_t;

  typedef enum logic [1:0] {
    pd_normal = 2'b00,
    pd_full = 2'b01,
    pd_standby = 2'b10
  } power_mode_t;

  localparam logic [2:0] requant_mode_22 = 3'b000;
  localparam logic [2:0] requant_mode_33 = 3'b001;
  localparam logic [5:0] tuning_count_22 = 6'h39;
  localparam logic [5:0] tuning_count_33 = 6'h22;

  localparam logic [1:0] fmt_reset = 2'b01;
  localparam logic dcs_enable_reset = 1'b1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int latency_plain = 10;
  localparam int latency_requant = 13;
  localparam int clock_hz = 50000000;
  localparam int dcs_min_hz = 40000000;
  localparam int relock_max_ns = 5000;
  localparam int relock_cycles = (relock_max_ns * (clock_hz / 1000000)) / 1000;
  localparam int sample_clock_hz_default = 50000000;

  // AXI4-Lite responses.
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

endpackage : adc_out_pkg

// ---- src/sample_delay.sv ----
// Per-channel delay line that places a sample and its overrange flag 10 or 13 samples late.
`timescale 1ns/1ns
`default_nettype none
module sample_delay
  import adc_out_pkg::*;
#(
  parameter int width = 11
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sample_strobe,
  input wire logic requant_on,
  input wire logic [width-1:0] sample_in,
  input wire logic over_in,
  output logic [width-1:0] sample_out,
  output logic over_out
);

  logic [width:0] stage [latency_requant];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < latency_requant; i++) begin
        stage[i] <= '0;
      end
    end else if (sample_strobe) begin
      stage[0] <= {over_in, sample_in};
      for (int i = 1; i < latency_requant; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  // Output tap selects 10 or 13 samples of latency, data and flag together.
  // The capture register ahead of the line and the output register behind it each add one sample,
  // so the tap sits two stages short of the latency.
  assign {over_out, sample_out} = requant_on ? stage[latency_requant-2] : stage[latency_plain-2];

endmodule : sample_delay
`default_nettype wire

// ---- src/dual_adc_output_control.sv ----
// Output formatting, three-state, power and stabilizer control of a dual 11-bit converter.
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_control
  import adc_out_pkg::*;
#(
  parameter int sample_width = 11,
  parameter int sample_clock_hz = sample_clock_hz_default
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic sample_clock,
  input wire logic [sample_width-1:0] conv_a,
  input wire logic [1:0] range_a,
  input wire logic [sample_width-1:0] conv_b,
  input wire logic [1:0] range_b,
  input wire logic output_enable_n,
  input wire logic power_down_pin,
  output logic [sample_width-1:0] data_out,
  output logic data_out_oe_n,
  output logic over_out,
  output logic data_output_clock,
  output logic reference_on,
  output logic duty_cycle_stabilizer_on
);

  initial begin
    if (sample_width < 2) $error("sample_width too small");
  end

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Range code: 00 inside, 01 strictly above plus full scale, 10 strictly below minus.
  function automatic logic [sample_width-1:0] encode(input logic [sample_width-1:0] ob, input logic [1:0] fmt,
                                                   input logic requant);
    logic [sample_width-1:0] v;
    logic [sample_width-1:0] mid;
    logic signed [sample_width:0] sv;
    v = ob;
    mid = {1'b1, {(sample_width-1){1'b0}}};
    sv = '0;
    // Scale toward midscale by about 0.6 dB (x 15/16) when requantizing.
    if (requant) begin
      sv = $signed({1'b0, ob}) - $signed({1'b0, mid});
      sv = sv - (sv >>> 4);
      v = sample_width'(sv + $signed({1'b0, mid}));
    end
    case (fmt)
      fmt_offset_binary: encode = v;
      fmt_twos_complement: encode = {~v[sample_width-1], v[sample_width-2:0]};
      fmt_gray: encode = v ^ (v >> 1);
      default: encode = v;
    endcase
  endfunction : encode

  // ==========================================================================
  // Control registers
  // ==========================================================================
  logic [1:0] fmt;
  logic out_disable_a;
  logic out_disable_b;
  logic [1:0] pd_mode;
  logic dcs_enable;
  logic requant_en_a;
  logic requant_en_b;
  logic [2:0] requant_mode;
  logic [5:0] tuning;
  logic tuning_bad;

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        addr_output_mode, addr_power_mode, addr_clock_control, addr_requant_control,
        addr_band_tuning: s_axi_bresp <= resp_okay;
        default: s_axi_bresp <= resp_slverr;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries fields; writes without it leave registers alone.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fmt <= fmt_reset;
      out_disable_a <= 1'b0;
      out_disable_b <= 1'b0;
      pd_mode <= pd_normal;
      dcs_enable <= dcs_enable_reset;
      requant_en_a <= 1'b0;
      requant_en_b <= 1'b0;
      requant_mode <= requant_mode_22;
      tuning <= '0;
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        addr_output_mode: begin
          fmt <= w_data[fmt_lsb +: 2];
          out_disable_a <= w_data[out_disable_bit];
          out_disable_b <= w_data[out_disable_bit+1];
        end
        addr_power_mode: pd_mode <= w_data[pd_mode_lsb +: 2];
        addr_clock_control: dcs_enable <= w_data[dcs_enable_bit];
        addr_requant_control: begin
          requant_en_a <= w_data[requant_en_a_bit];
          requant_en_b <= w_data[requant_en_b_bit];
          requant_mode <= w_data[requant_mode_lsb +: 3];
        end
        addr_band_tuning: tuning <= w_data[tuning_lsb +: 6];
        default: ;
      endcase
    end
  end

  // A tuning word at or above the count of the chosen mode is flagged for software; modes other than 22 and 33 always flag.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tuning_bad <= 1'b0;
    end else begin
      tuning_bad <= (requant_mode == requant_mode_22) ? (tuning >= tuning_count_22) :
                    (requant_mode == requant_mode_33) ? (tuning >= tuning_count_33) : 1'b1;
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  logic dcs_locked;
  logic powered_down;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= resp_okay;
      case (s_axi_araddr)
        addr_output_mode: s_axi_rdata <= {26'h0, out_disable_b, out_disable_a, 2'b00, fmt};
        addr_power_mode: s_axi_rdata <= {30'h0, pd_mode};
        addr_clock_control: s_axi_rdata <= {31'h0, dcs_enable};
        addr_requant_control: s_axi_rdata <= {27'h0, requant_mode, requant_en_b, requant_en_a};
        addr_band_tuning: s_axi_rdata <= {26'h0, tuning};
        addr_status: s_axi_rdata <= {29'h0, tuning_bad, powered_down, dcs_locked};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= resp_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Pin synchronisers and sample clock edge detection
  // ==========================================================================
  logic [2:0] sclk_sync;
  logic [1:0] oe_sync;
  logic [1:0] pd_sync;
  logic sample_rise;
  logic sample_fall;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync <= '0;
      oe_sync <= 2'b11;
      pd_sync <= 2'b00;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sample_clock};
      oe_sync <= {oe_sync[0], output_enable_n};
      pd_sync <= {pd_sync[0], power_down_pin};
    end
  end

  assign sample_rise = sclk_sync[1] && !sclk_sync[2];
  assign sample_fall = !sclk_sync[1] && sclk_sync[2];

  // Pin, or register in full or standby mode, forces power-down; pin low with register normal resumes.
  assign powered_down = pd_sync[1] || (pd_mode == pd_full) || (pd_mode == pd_standby);

  // Converter data is captured on the sampled rising edge, assumed stable by then.
  logic [sample_width-1:0] cap_a;
  logic [sample_width-1:0] cap_b;
  logic cap_over_a;
  logic cap_over_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cap_a <= '0;
      cap_b <= '0;
      cap_over_a <= 1'b0;
      cap_over_b <= 1'b0;
    end else if (sample_rise) begin
      cap_a <= conv_a;
      cap_b <= conv_b;
      cap_over_a <= |range_a;
      cap_over_b <= |range_b;
    end
  end

  // ==========================================================================
  // Pipeline delay
  // ==========================================================================
  logic [sample_width-1:0] late_a;
  logic [sample_width-1:0] late_b;
  logic late_over_a;
  logic late_over_b;

  sample_delay #(.width(sample_width)) delay_a (
    .clock(clock),
    .rst_b(rst_b),
    .sample_strobe(sample_rise),
    .requant_on(requant_en_a),
    .sample_in(cap_a),
    .over_in(cap_over_a),
    .sample_out(late_a),
    .over_out(late_over_a)
  );

  sample_delay #(.width(sample_width)) delay_b (
    .clock(clock),
    .rst_b(rst_b),
    .sample_strobe(sample_rise),
    .requant_on(requant_en_b),
    .sample_in(cap_b),
    .over_in(cap_over_b),
    .sample_out(late_b),
    .over_out(late_over_b)
  );

  // ==========================================================================
  // Interleaved output
  // ==========================================================================
  // With both channels enabled, channel A rides the high phase, channel B the low phase of the data clock; a lone enabled channel fills both.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= '0;
      over_out <= 1'b0;
      data_output_clock <= 1'b0;
    end else if (sample_rise) begin
      data_output_clock <= 1'b1;
      if (out_disable_a && !out_disable_b) begin
        data_out <= encode(late_b, fmt, requant_en_b);
        over_out <= late_over_b;
      end else begin
        data_out <= encode(late_a, fmt, requant_en_a);
        over_out <= late_over_a;
      end
    end else if (sample_fall) begin
      data_output_clock <= 1'b0;
      if (out_disable_b && !out_disable_a) begin
        data_out <= encode(late_a, fmt, requant_en_a);
        over_out <= late_over_a;
      end else begin
        data_out <= encode(late_b, fmt, requant_en_b);
        over_out <= late_over_b;
      end
    end
  end

  // Drivers float for the pin, power-down, or both channels disabled.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_out_oe_n <= 1'b1;
    end else begin
      data_out_oe_n <= oe_sync[1] || powered_down || (out_disable_a && out_disable_b);
    end
  end

  // Standby keeps the reference powered; only the pin or full power-down mode drops it.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reference_on <= 1'b1;
    end else begin
      reference_on <= !(pd_sync[1] || (pd_mode == pd_full));
    end
  end

  // ==========================================================================
  // Duty cycle stabilizer lock model
  // ==========================================================================
  // The stabilizer is modelled by its lock state; the regenerated falling edge itself is analog.
  // A rate below 40 MHz never locks; a parameter stands in for the measured rate.
  logic [12:0] relock_count;
  localparam logic rate_ok = (sample_clock_hz >= dcs_min_hz);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      relock_count <= '0;
      dcs_locked <= 1'b0;
    end else if (!dcs_enable || !rate_ok || powered_down) begin
      relock_count <= '0;
      dcs_locked <= 1'b0;
    end else if (relock_count != 13'(relock_cycles)) begin
      relock_count <= relock_count + 13'h0001;
    end else begin
      dcs_locked <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      duty_cycle_stabilizer_on <= 1'b0;
    end else begin
      duty_cycle_stabilizer_on <= dcs_locked;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_pin_tristate;
    @(posedge clock) disable iff (!rst_b) oe_sync[1] |=> data_out_oe_n;
  endproperty
  a_pin_tristate: assert property (p_pin_tristate) else $error("outputs driven with enable pin high");

  property p_pd_tristate;
    @(posedge clock) disable iff (!rst_b) $rose(pd_sync[1]) |=> data_out_oe_n [*2];
  endproperty
  a_pd_tristate: assert property (p_pd_tristate) else $error("outputs driven in power-down");

  property p_resume;
    @(posedge clock) disable iff (!rst_b)
      (!pd_sync[1] && pd_mode == pd_normal && !oe_sync[1] && !(out_disable_a && out_disable_b)) |=> !data_out_oe_n;
  endproperty
  a_resume: assert property (p_resume) else $error("outputs not driven in normal mode");

  property p_standby_ref;
    @(posedge clock) disable iff (!rst_b) (pd_mode == pd_standby && !pd_sync[1]) |=> reference_on;
  endproperty
  a_standby_ref: assert property (p_standby_ref) else $error("reference off in standby");

  property p_dco_rise;
    @(posedge clock) disable iff (!rst_b) sample_rise |=> data_output_clock;
  endproperty
  a_dco_rise: assert property (p_dco_rise) else $error("data clock missed rising phase");

  property p_repeat_a;
    @(posedge clock) disable iff (!rst_b)
      (sample_fall && out_disable_b && !out_disable_a) |=> (data_out == $past(data_out)) && !data_output_clock;
  endproperty
  a_repeat_a: assert property (p_repeat_a) else $error("interleave phase wrong");

  property p_no_lock_slow;
    @(posedge clock) disable iff (!rst_b) (!rate_ok || !dcs_enable) |=> !dcs_locked;
  endproperty
  a_no_lock_slow: assert property (p_no_lock_slow) else $error("stabilizer locked when it cannot");

  property p_over_strict;
    @(posedge clock) disable iff (!rst_b) (sample_rise && range_a == 2'b00) |=> !cap_over_a;
  endproperty
  a_over_strict: assert property (p_over_strict) else $error("overrange set inside full scale");

endmodule : dual_adc_output_control
`default_nettype wire

// ---- test/capture_model.sv ----
// Far-side capture register that latches both interleaved words each data clock period.
`timescale 1ns/1ns
`default_nettype none
module capture_model #(
  parameter int width = 11
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [width-1:0] data_out,
  input wire logic data_out_oe_n,
  input wire logic over_out,
  input wire logic data_output_clock,
  output logic [width-1:0] cap_a,
  output logic [width-1:0] cap_b,
  output logic over_a,
  output logic over_b,
  output logic got
);
  // ==========================================================================
  // Mid-phase capture
  // ==========================================================================
  // A released bus shows a pattern that flips every cycle, so stale data never passes.
  logic [width-1:0] last;
  logic dco_q;
  logic [2:0] age;
  wire logic [width-1:0] bus = data_out_oe_n ? ~last : data_out;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {last, dco_q, age, cap_a, cap_b, over_a, over_b, got} <= '0;
    end else begin
      last <= bus;
      dco_q <= data_output_clock;
      got <= 1'h0;
      age <= (data_output_clock != dco_q) ? 3'h1 : ((age != 3'h0) ? age + 3'h1 : age);
      // Sampling three cycles into a four-cycle phase keeps clear of both word edges.
      if (age == 3'h2 && dco_q) begin
        cap_a <= bus;
        over_a <= over_out;
      end else if (age == 3'h2) begin
        cap_b <= bus;
        over_b <= over_out;
        got <= 1'h1;
      end
    end
  end
endmodule : capture_model
`default_nettype wire

// ---- test/dual_adc_output_control_tb.sv ----
// Self-checking bench for the dual converter output control block.
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_control_tb;
  import adc_out_pkg::*;
  typedef struct {logic [35:0] v; logic [35:0] m;} note_t;
  logic clock = '0, rst_b = '0, sample_clock = '0, probe_q = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [10:0] conv_a = '0, conv_b = '0, data_out, cap_a, cap_b, a, b, old;
  logic [1:0] range_a = '0, range_b = '0, s_axi_bresp, s_axi_rresp;
  logic output_enable_n = '0, power_down_pin = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, data_out_oe_n, over_out, data_output_clock, reference_on, duty_cycle_stabilizer_on;
  logic over_a, over_b, got;
  logic [35:0] probe_val = '0;
  wire logic [35:0] pins = {34'h0, data_out_oe_n, reference_on};
  note_t notes[$];
  int err_total = 0, compares = 0, seed = 39, n, k;
  dual_adc_output_control uut (.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sample_clock,
    .conv_a, .range_a, .conv_b, .range_b, .output_enable_n, .power_down_pin, .data_out, .data_out_oe_n,
    .over_out, .data_output_clock, .reference_on, .duty_cycle_stabilizer_on);
  capture_model cap (.clock, .rst_b, .data_out, .data_out_oe_n, .over_out, .data_output_clock, .cap_a, .cap_b,
    .over_a, .over_b, .got);
  // ==========================================================================
  // Clocks, watchdog and result checking
  // ==========================================================================
  initial forever #10 clock = ~clock;
  initial begin
    #7;
    forever #80 sample_clock = ~sample_clock;
  end
  initial begin
    #1500000;
    err_total++;
    summarize;
  end
  task automatic summarize;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [35:0] v);
    note_t e;
    compares++;
    e = notes.size() ? notes.pop_front() : '{36'h0, 36'h0};
    if ((v & e.m) !== (e.v & e.m) || e.m == 36'h0) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, v & e.m, e.v & e.m);
    end
  endtask : check
  always @(posedge clock) begin
    if (s_axi_bvalid && s_axi_bready) check({2'h0, s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) check({2'h0, s_axi_rresp, s_axi_rdata});
    if (probe_q) check(probe_val);
  end
  // ==========================================================================
  // Drivers
  // ==========================================================================
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = resp_okay);
    notes.push_back('{{2'h0, r, 32'h0}, 36'h3_0000_0000});
    @(posedge clock);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= ad;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 100 && !(s_axi_bvalid && s_axi_bready); n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r = resp_okay);
    notes.push_back('{{2'h0, r, d}, {4'h3, m}});
    @(posedge clock);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= ad;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 100 && !(s_axi_rvalid && s_axi_rready); n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic probe(input logic [35:0] e, input logic [35:0] v);
    notes.push_back('{e, 36'hf_ffff_ffff});
    @(posedge clock);
    probe_val <= v;
    probe_q <= 1'h1;
    @(posedge clock);
    probe_q <= 1'h0;
  endtask : probe
  task automatic next_word;
    for (n = 0; n < 100 && !got; n++) @(posedge clock);
    @(posedge clock);
  endtask : next_word
  function automatic logic [10:0] fmt(input int f, input logic [10:0] x);
    return (f == 0) ? x : ((f == 1) ? x ^ 11'h400 : x ^ (x >> 1));
  endfunction : fmt
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    repeat (300) @(posedge clock);
    rd(addr_output_mode, 32'h1, 32'h33);
    rd(addr_clock_control, 32'h1, 32'h1);
    rd(addr_status, 32'h1, 32'h3);
    for (int f = 0; f < 3; f++) begin
      for (int j = 0; j < 2; j++) begin
        a = j ? 11'h400 : 11'h000;
        b = j ? 11'($random(seed)) : 11'h7ff;
        conv_a <= a;
        conv_b <= b;
        range_b <= j ? 2'h2 : 2'h1;
        wr(addr_output_mode, 32'(f));
        repeat (200) @(posedge clock);
        next_word;
        probe({12'h0, 1'h0, fmt(f, a), 1'h1, fmt(f, b)}, {12'h0, over_a, cap_a, over_b, cap_b});
      end
    end
    for (int d = 1; d < 3; d++) begin
      wr(addr_output_mode, 32'(d) << 4);
      repeat (30) @(posedge clock);
      next_word;
      probe((d == 1) ? {12'h0, 1'h1, b, 1'h1, b} : {12'h0, 1'h0, a, 1'h0, a}, {12'h0, over_a, cap_a, over_b, cap_b});
    end
    wr(addr_output_mode, 32'h1);
    // Latency is counted in whole data clock periods from the sampling rise.
    for (int q = 0; q < 2; q++) begin
      wr(addr_requant_control, 32'(q));
      conv_a <= 11'h400;
      range_a <= 2'h0;
      repeat (300) @(posedge clock);
      next_word;
      old = cap_a;
      @(negedge sample_clock);
      @(posedge clock);
      conv_a <= 11'h7ff;
      range_a <= 2'h1;
      @(posedge sample_clock);
      @(posedge data_output_clock);
      for (k = 1; k < 20; k++) begin
        next_word;
        if (cap_a !== old) break;
      end
      probe({27'h0, 1'h1, q ? 8'(latency_requant) : 8'(latency_plain)}, {27'h0, over_a, 8'(k - 1)});
    end
    for (int t = 0; t < 4; t++) begin
      wr(addr_requant_control, (t > 1) ? 32'h4 : 32'h0);
      wr(addr_band_tuning, 32'(((t > 1) ? tuning_count_33 : tuning_count_22) - (t[0] ? 6'h0 : 6'h1)));
      rd(addr_status, {29'h0, t[0], 2'h0}, 32'h4);
    end
    output_enable_n <= 1'h1;
    repeat (10) @(posedge clock);
    probe(36'h3, pins);
    output_enable_n <= 1'h0;
    power_down_pin <= 1'h1;
    repeat (10) @(posedge clock);
    probe(36'h2, pins);
    rd(addr_status, 32'h2, 32'h2);
    power_down_pin <= 1'h0;
    repeat (10) @(posedge clock);
    probe(36'h1, pins);
    for (int p = 2; p >= 0; p--) begin
      wr(addr_power_mode, 32'(p));
      repeat (5) @(posedge clock);
      probe({34'h0, p != 0, p != 1}, pins);
    end
    wr(8'h20, 32'h0, resp_slverr);
    rd(8'h20, 32'h0, 32'h0, resp_slverr);
    wr(addr_clock_control, 32'h0);
    rd(addr_status, 32'h0, 32'h1);
    wr(addr_clock_control, 32'h1);
    repeat (300) @(posedge clock);
    rd(addr_status, 32'h1, 32'h1);
    repeat (5) @(posedge clock);
    summarize;
  end
endmodule : dual_adc_output_control_tb
`default_nettype wire
